// ### hw/ldc_defines.vh
/*
 * Constants for the display configuration register bank: register selectors,
 * field positions and reset values.
 * Assumes inclusion by bare name from the design files only.
 */
`ifndef LDC_DEFINES_VH
`define LDC_DEFINES_VH

// ==========================================================================
// Register selectors carried with each write or read request
// ==========================================================================
`define LDC_SEL_SCAN_CLK      1'b0
`define LDC_SEL_GRAY_TIMING   1'b1

// ==========================================================================
// Field positions of scan_and_clock_config
// ==========================================================================
`define LDC_CHAIN_LSB         0
`define LDC_PREDIS_BIT        8
`define LDC_PSAVE_BIT         12
`define LDC_PSP_LSB           13
`define LDC_OPEN_RM_BIT       15
`define LDC_SCAN_LSB          16
`define LDC_SUBP_LSB          22
`define LDC_RANGE_BIT         28
`define LDC_MULT_LSB          29
`define LDC_DLY_R_LSB         36
`define LDC_DLY_G_LSB         39
`define LDC_DLY_B_LSB         42
`define LDC_SHORT_RM_BIT      47

// ==========================================================================
// Field positions of grayscale_timing_config
// ==========================================================================
`define LDC_SEG_LSB           0
`define LDC_SMOOTH_R_LSB      10
`define LDC_SMOOTH_G_LSB      15
`define LDC_SMOOTH_B_LSB      20
`define LDC_BOOST_R_LSB       25
`define LDC_BOOST_G_LSB       29
`define LDC_BOOST_B_LSB       33
`define LDC_LSW_LSB           37
`define LDC_BLACK_LSB         41

// ==========================================================================
// Writable masks and reset images (reserved bits hold fixed values)
// ==========================================================================
`define LDC_CFG0_WMASK        48'h9FF1_F1FF_F11F
`define LDC_CFG0_FIXED        48'h2000_0000_0000
`define LDC_CFG0_RESET        48'h2000_E000_0107
`define LDC_CFG1_WMASK        48'h7FFF_FFFF_FFFF
`define LDC_CFG1_FIXED        48'h0000_0000_0000
`define LDC_CFG1_RESET        48'h00E0_0094_A400

// ==========================================================================
// Timing figures in grayscale clocks
// ==========================================================================
`define LDC_SEG_MIN_CODE      10'h07F
`define LDC_SEG_DEFAULT_LEN   11'h080
`define LDC_LSW_ZERO_LEN      10'h02D
`define LDC_LSW_STEP_LEN      10'h01E
`define LDC_SUBP_STEP         8'h10

`endif

// ### hw/ldc_cfg_store.v
/*
 * Two-word store holding the two 48-bit configuration registers.
 * Assumes a single clock and active-low asynchronous reset; read data
 * comes out of a register one cycle after the request.
 */
`include "ldc_defines.vh"

module ldc_cfg_store #(
   parameter WIDTH = 48
) (
   // Clock and reset.
   input  wire             clk_sys,
   input  wire             rstn,
   // Write side.
   input  wire             wr_en,
   input  wire             wr_sel,
   input  wire [WIDTH-1:0] wr_data,
   // Read side.
   input  wire             rd_sel,
   output reg  [WIDTH-1:0] rd_data,
   // Live images.
   output reg  [WIDTH-1:0] cfg0_r,
   output reg  [WIDTH-1:0] cfg1_r
);

   // ========================================================================
   // Storage
   // ========================================================================
   // Reserved bits are forced to their fixed values; writes never reach them.
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cfg0_r <= `LDC_CFG0_RESET;
         cfg1_r <= `LDC_CFG1_RESET;
         rd_data <= {WIDTH{1'b0}};
      end else begin
         if (wr_en && wr_sel == `LDC_SEL_SCAN_CLK)
            cfg0_r <= (wr_data & `LDC_CFG0_WMASK) | `LDC_CFG0_FIXED;
         if (wr_en && wr_sel == `LDC_SEL_GRAY_TIMING)
            cfg1_r <= (wr_data & `LDC_CFG1_WMASK) | `LDC_CFG1_FIXED;
         rd_data <= (rd_sel == `LDC_SEL_SCAN_CLK) ? cfg0_r : cfg1_r;
      end
   end

endmodule // ldc_cfg_store

// ### hw/ldc_config_regs.v
/*
 * Common configuration register bank of the LED matrix driver: stores the
 * two 48-bit words written by serial-chain commands and decodes them into
 * the counts, enables and timings used by the display engine.
 * Assumes the serial front end delivers whole decoded words with a
 * one-cycle write or read strobe, synchronous to clk_sys.
 */
`include "ldc_defines.vh"

module ldc_config_regs #(
   parameter WIDTH = 48
) (
   // Clock and reset.
   input  wire             clk_sys,
   input  wire             rstn,
   // Command port from the serial front end.
   input  wire             cmd_wr,
   input  wire             cmd_rd,
   input  wire             cmd_sel,
   input  wire [WIDTH-1:0] cmd_wdata,
   output reg  [WIDTH-1:0] cmd_rdata,
   output reg              cmd_rvalid,
   // Display engine inputs.
   input  wire             forward_pwm,
   input  wire             seg_tick,
   // Decoded counts.
   output reg  [5:0]       chain_devices,
   output reg  [6:0]       scan_lines,
   output reg  [7:0]       subperiods,
   output reg  [4:0]       gray_clock_multiplier,
   output reg              gray_clock_range_select,
   // Decoded enables.
   output reg              predischarge_enable,
   output reg              power_saving_enable,
   output reg  [1:0]       power_saving_plus_level,
   output reg              open_led_removal_enable,
   output reg              short_led_removal_enable,
   // Colour group delays in grayscale clocks.
   output reg  [2:0]       red_group_delay,
   output reg  [2:0]       green_group_delay,
   output reg  [2:0]       blue_group_delay,
   // Low grayscale tuning.
   output reg  [5:0]       red_low_gray_smoothing,
   output reg  [5:0]       green_low_gray_smoothing,
   output reg  [5:0]       blue_low_gray_smoothing,
   output reg  [3:0]       red_low_gray_boost,
   output reg  [3:0]       green_low_gray_boost,
   output reg  [3:0]       blue_low_gray_boost,
   // Segment timing in grayscale clocks.
   output reg  [10:0]      segment_gray_clocks,
   output reg  [9:0]       line_switch_time,
   output reg  [11:0]      segment_total_clocks,
   output reg  [5:0]       black_field_adjust,
   // Scan position.
   output reg  [5:0]       scan_line_index,
   output reg  [6:0]       subperiod_index
);

   // ========================================================================
   // Storage
   // ========================================================================
   wire [WIDTH-1:0] cfg0;
   wire [WIDTH-1:0] cfg1;
   wire [WIDTH-1:0] store_rdata;
   reg              rd_pend_r;

   ldc_cfg_store #(
      .WIDTH   (WIDTH)
   ) u_store (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .wr_en   (cmd_wr),
      .wr_sel  (cmd_sel),
      .wr_data (cmd_wdata),
      .rd_sel  (cmd_sel),
      .rd_data (store_rdata),
      .cfg0_r  (cfg0),
      .cfg1_r  (cfg1)
   );

   // ========================================================================
   // Decode helpers
   // ========================================================================
   // Segment length: codes below 127 fall back to 128 clocks.
   function [10:0] seg_len;
      input [9:0] code;
      begin
         if (code >= `LDC_SEG_MIN_CODE)
            seg_len = {1'b0, code} + 11'h001;
         else
            seg_len = `LDC_SEG_DEFAULT_LEN;
      end
   endfunction

   // Line switch: zero is a special short switch, others step by 30.
   function [9:0] lsw_len;
      input [3:0] code;
      reg   [4:0] steps;
      begin
         steps = {1'b0, code} + 5'h01;
         if (code == 4'h0)
            lsw_len = `LDC_LSW_ZERO_LEN;
         else
            lsw_len = steps * `LDC_LSW_STEP_LEN;
      end
   endfunction

   // Group delays are only honoured while forward PWM is running.
   function [2:0] fwd_dly;
      input [2:0] code;
      input       fwd;
      begin
         fwd_dly = fwd ? code : 3'h0;
      end
   endfunction

   // ========================================================================
   // Read path
   // ========================================================================
   // Store output is registered, so the answer follows the request by two.
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rd_pend_r  <= 1'b0;
         cmd_rvalid <= 1'b0;
         cmd_rdata  <= {WIDTH{1'b0}};
      end else begin
         rd_pend_r  <= cmd_rd;
         cmd_rvalid <= rd_pend_r;
         if (rd_pend_r)
            cmd_rdata <= store_rdata;
      end
   end

   // ========================================================================
   // Field decode
   // ========================================================================
   // Registered so every output comes from a flip-flop; one cycle behind.
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         chain_devices            <= 6'h08;
         scan_lines               <= 7'h01;
         subperiods               <= 8'h10;
         gray_clock_multiplier    <= 5'h08;
         gray_clock_range_select  <= 1'b0;
         predischarge_enable      <= 1'b1;
         power_saving_enable      <= 1'b0;
         power_saving_plus_level  <= 2'h0;
         open_led_removal_enable  <= 1'b0;
         short_led_removal_enable <= 1'b0;
         red_group_delay          <= 3'h0;
         green_group_delay        <= 3'h0;
         blue_group_delay         <= 3'h0;
         red_low_gray_smoothing   <= 6'h0A;
         green_low_gray_smoothing <= 6'h0A;
         blue_low_gray_smoothing  <= 6'h0A;
         red_low_gray_boost       <= 4'h0;
         green_low_gray_boost     <= 4'h0;
         blue_low_gray_boost      <= 4'h0;
         segment_gray_clocks      <= 11'h080;
         line_switch_time         <= 10'h0F0;
         segment_total_clocks     <= 12'h170;
         black_field_adjust       <= 6'h00;
      end else begin
         chain_devices            <= {1'b0, cfg0[`LDC_CHAIN_LSB +: 5]} + 6'h01;
         predischarge_enable      <= cfg0[`LDC_PREDIS_BIT];
         power_saving_enable      <= cfg0[`LDC_PSAVE_BIT];
         power_saving_plus_level  <= cfg0[`LDC_PSP_LSB +: 2];
         open_led_removal_enable  <= cfg0[`LDC_OPEN_RM_BIT];
         scan_lines               <= {1'b0, cfg0[`LDC_SCAN_LSB +: 6]} + 7'h01;
         subperiods               <= ({5'h00, cfg0[`LDC_SUBP_LSB +: 3]} + 8'h01) << 4;
         gray_clock_range_select  <= cfg0[`LDC_RANGE_BIT];
         gray_clock_multiplier    <= {1'b0, cfg0[`LDC_MULT_LSB +: 4]} + 5'h01;
         red_group_delay          <= fwd_dly(cfg0[`LDC_DLY_R_LSB +: 3], forward_pwm);
         green_group_delay        <= fwd_dly(cfg0[`LDC_DLY_G_LSB +: 3], forward_pwm);
         blue_group_delay         <= fwd_dly(cfg0[`LDC_DLY_B_LSB +: 3], forward_pwm);
         short_led_removal_enable <= cfg0[`LDC_SHORT_RM_BIT];
         segment_gray_clocks      <= seg_len(cfg1[`LDC_SEG_LSB +: 10]);
         red_low_gray_smoothing   <= {1'b0, cfg1[`LDC_SMOOTH_R_LSB +: 5]} + 6'h01;
         green_low_gray_smoothing <= {1'b0, cfg1[`LDC_SMOOTH_G_LSB +: 5]} + 6'h01;
         blue_low_gray_smoothing  <= {1'b0, cfg1[`LDC_SMOOTH_B_LSB +: 5]} + 6'h01;
         red_low_gray_boost       <= cfg1[`LDC_BOOST_R_LSB +: 4];
         green_low_gray_boost     <= cfg1[`LDC_BOOST_G_LSB +: 4];
         blue_low_gray_boost      <= cfg1[`LDC_BOOST_B_LSB +: 4];
         line_switch_time         <= lsw_len(cfg1[`LDC_LSW_LSB +: 4]);
         black_field_adjust       <= cfg1[`LDC_BLACK_LSB +: 6];
         segment_total_clocks     <= {1'b0, seg_len(cfg1[`LDC_SEG_LSB +: 10])}
                                   + {2'b00, lsw_len(cfg1[`LDC_LSW_LSB +: 4])};
      end
   end

   // ========================================================================
   // Scan position
   // ========================================================================
   // One segment per scan line; after the last line the subperiod advances.
   // Compares against the live field so a reprogrammed count wraps cleanly.
   wire [5:0] last_line = cfg0[`LDC_SCAN_LSB +: 6];
   wire [6:0] last_subp = {cfg0[`LDC_SUBP_LSB +: 3], 4'hF};

   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         scan_line_index <= 6'h00;
         subperiod_index <= 7'h00;
      end else if (seg_tick) begin
         if (scan_line_index >= last_line) begin
            scan_line_index <= 6'h00;
            if (subperiod_index >= last_subp)
               subperiod_index <= 7'h00;
            else
               subperiod_index <= subperiod_index + 7'h01;
         end else begin
            scan_line_index <= scan_line_index + 6'h01;
         end
      end
   end

endmodule // ldc_config_regs

// ### tb/ldc_cfg_monitor.sv
/*
 * Port checker of the configuration bank: decoded fields after writes,
 * colour delays outside forward mode and the scan line position.
 * Assumes a bind onto ldc_config_regs and a single clock domain.
 */
module ldc_cfg_monitor #(
   parameter int WIDTH = 48
) (
   // Clock, reset and command port.
   input logic             clk_sys,
   input logic             rstn,
   input logic             cmd_wr,
   input logic             cmd_sel,
   input logic [WIDTH-1:0] cmd_wdata,
   // Engine inputs.
   input logic             forward_pwm,
   input logic             seg_tick,
   // Decoded outputs.
   input logic [5:0]       chain_devices,
   input logic [6:0]       scan_lines,
   input logic [7:0]       subperiods,
   input logic [4:0]       gray_clock_multiplier,
   input logic [2:0]       red_group_delay,
   input logic [2:0]       green_group_delay,
   input logic [2:0]       blue_group_delay,
   input logic [10:0]      segment_gray_clocks,
   input logic [9:0]       line_switch_time,
   input logic [5:0]       scan_line_index,
   input logic [6:0]       subperiod_index
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);

   // ======================================================================
   // Decoded fields, two edges after the write that carries them.
   // ======================================================================
   property p_chain;
      cmd_wr && !cmd_sel |-> ##2 chain_devices == {1'b0, $past(cmd_wdata[4:0], 2)} + 6'h01;
   endproperty
   a_chain: assert property (p_chain) else $error("chain count mismatch");
   property p_scan;
      cmd_wr && !cmd_sel |-> ##2 scan_lines == {1'b0, $past(cmd_wdata[21:16], 2)} + 7'h01;
   endproperty
   a_scan: assert property (p_scan) else $error("scan line count mismatch");
   property p_subp;
      cmd_wr && !cmd_sel |-> ##2 subperiods == {1'b0, $past(cmd_wdata[24:22], 2), 4'h0} + 8'h10;
   endproperty
   a_subp: assert property (p_subp) else $error("subperiod count mismatch");
   property p_mult;
      cmd_wr && !cmd_sel |-> ##2 gray_clock_multiplier == {1'b0, $past(cmd_wdata[32:29], 2)} + 5'h01;
   endproperty
   a_mult: assert property (p_mult) else $error("multiplier mismatch");
   property p_seg;
      cmd_wr && cmd_sel |-> ##2 segment_gray_clocks == (($past(cmd_wdata[9:0], 2) >= 10'h07F) ?
         {1'b0, $past(cmd_wdata[9:0], 2)} + 11'h001 : 11'h080);
   endproperty
   a_seg: assert property (p_seg) else $error("segment length mismatch");
   property p_lsw;
      cmd_wr && cmd_sel |-> ##2 line_switch_time == (($past(cmd_wdata[40:37], 2) == 4'h0) ? 10'h02D :
         ({6'h00, $past(cmd_wdata[40:37], 2)} + 10'h001) * 10'h01E);
   endproperty
   a_lsw: assert property (p_lsw) else $error("line switch time mismatch");

   // ======================================================================
   // Delays and scan position.
   // ======================================================================
   // Two low samples are asked for, so a one-stage lag in the design is tolerated.
   property p_delay;
      !forward_pwm [*2] |=> {red_group_delay, green_group_delay, blue_group_delay} == 9'h000;
   endproperty
   a_delay: assert property (p_delay) else $error("group delay outside forward mode");
   property p_idx;
      seg_tick |=> scan_line_index == (({1'b0, $past(scan_line_index)} == $past(scan_lines) - 7'h01) ?
         6'h00 : $past(scan_line_index) + 6'h01);
   endproperty
   a_idx: assert property (p_idx) else $error("scan line index step wrong");

   c_seg: cover property (cmd_wr && cmd_sel ##2 segment_gray_clocks == 11'h080);
   c_wrap: cover property (seg_tick ##1 scan_line_index == 6'h00 && subperiod_index != 7'h00);
   c_fwd: cover property (!forward_pwm [*2]);
endmodule // ldc_cfg_monitor

bind ldc_config_regs ldc_cfg_monitor #(.WIDTH(WIDTH)) ldc_mon_u (
   .clk_sys, .rstn, .cmd_wr, .cmd_sel, .cmd_wdata, .forward_pwm, .seg_tick, .chain_devices,
   .scan_lines, .subperiods, .gray_clock_multiplier, .red_group_delay, .green_group_delay,
   .blue_group_delay, .segment_gray_clocks, .line_switch_time, .scan_line_index, .subperiod_index
);

// ### tb/tb_led_matrix_display_config_regs.sv
/*
 * Self-checking bench of the configuration bank: a table of writes with
 * readback and decode checks, a sweep of field codes, then reset and scan.
 * Assumes the checker is bound in from its own file.
 */
module tb_led_matrix_display_config_regs;
   timeunit 1ns;
   timeprecision 100ps;
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
   typedef struct packed {logic sel; logic [47:0] wd; logic [47:0] rd;} ldc_row_t;
   localparam logic [47:0] RST0 = 48'h2000_E000_0107;
   localparam logic [47:0] RST1 = 48'h00E0_0094_A400;
   // Reserved bits in the expected readback keep their fixed values.
   localparam ldc_row_t ROWS [8] = '{
      '{1'b0, 48'hFFFF_FFFF_FFFF, 48'hBFF1_F1FF_F11F}, '{1'b0, 48'h0000_0000_0000, 48'h2000_0000_0000},
      '{1'b0, 48'h5555_5555_5555, 48'h3551_5155_5115}, '{1'b0, 48'hAAAA_AAAA_AAAA, 48'hAAA0_A0AA_A00A},
      '{1'b1, 48'hFFFF_FFFF_FFFF, 48'h7FFF_FFFF_FFFF}, '{1'b1, 48'h0000_0000_0000, 48'h0000_0000_0000},
      '{1'b1, 48'h5555_5555_507E, 48'h5555_5555_507E}, '{1'b1, 48'hAAAA_AAAA_A87F, 48'h2AAA_AAAA_A87F}};
   logic        clk_sys, rstn, cmd_wr, cmd_rd, cmd_sel, cmd_rvalid, forward_pwm, seg_tick;
   logic        predischarge_enable, power_saving_enable, open_led_removal_enable, short_led_removal_enable;
   logic        gray_clock_range_select;
   logic [1:0]  power_saving_plus_level;
   logic [2:0]  red_group_delay, green_group_delay, blue_group_delay;
   logic [3:0]  red_low_gray_boost, green_low_gray_boost, blue_low_gray_boost;
   logic [4:0]  gray_clock_multiplier;
   logic [5:0]  chain_devices, black_field_adjust, scan_line_index;
   logic [5:0]  red_low_gray_smoothing, green_low_gray_smoothing, blue_low_gray_smoothing;
   logic [6:0]  scan_lines, subperiod_index;
   logic [7:0]  subperiods;
   logic [9:0]  line_switch_time;
   logic [10:0] segment_gray_clocks;
   logic [11:0] segment_total_clocks;
   logic [47:0] cmd_wdata, cmd_rdata, m0, m1;
   int          err_count, compares;

   ldc_config_regs #(.WIDTH(48)) dut_u (
      .clk_sys, .rstn, .cmd_wr, .cmd_rd, .cmd_sel, .cmd_wdata, .cmd_rdata, .cmd_rvalid, .forward_pwm,
      .seg_tick, .chain_devices, .scan_lines, .subperiods, .gray_clock_multiplier, .gray_clock_range_select,
      .predischarge_enable, .power_saving_enable, .power_saving_plus_level, .open_led_removal_enable,
      .short_led_removal_enable, .red_group_delay, .green_group_delay, .blue_group_delay,
      .red_low_gray_smoothing, .green_low_gray_smoothing, .blue_low_gray_smoothing, .red_low_gray_boost,
      .green_low_gray_boost, .blue_low_gray_boost, .segment_gray_clocks, .line_switch_time,
      .segment_total_clocks, .black_field_adjust, .scan_line_index, .subperiod_index);

   // ======================================================================
   // Tasks.
   // ======================================================================
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // A write ends on the edge that takes it, so a read may follow at once.
   task automatic wr(input logic s, input logic [47:0] d);
      @(posedge clk_sys);
      cmd_wr <= 1'b1;
      cmd_sel <= s;
      cmd_wdata <= d;
      @(posedge clk_sys);
      cmd_wr <= 1'b0;
   endtask
   task automatic rd(input logic s, input logic [47:0] e);
      int n;
      cmd_rd <= 1'b1;
      cmd_sel <= s;
      @(posedge clk_sys);
      cmd_rd <= 1'b0;
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (cmd_rvalid !== 1'b1 && n < 6);
      `CHK(n, 2)
      `CHK(cmd_rdata, e)
      @(negedge clk_sys);
      `CHK(cmd_rvalid, 1'b0)
      @(posedge clk_sys);
   endtask
   // Decoded outputs trail a write by two edges, hence the wait.
   task automatic chk_dec();
      logic [10:0] sg;
      logic [9:0]  ls;
      logic [8:0]  dl;
      logic [17:0] sm;
      sg = (m1[9:0] >= 10'h07F) ? {1'b0, m1[9:0]} + 11'h001 : 11'h080;
      ls = (m1[40:37] == 4'h0) ? 10'h02D : ({6'h00, m1[40:37]} + 10'h001) * 10'h01E;
      sm = {{1'b0, m1[14:10]} + 6'h01, {1'b0, m1[19:15]} + 6'h01, {1'b0, m1[24:20]} + 6'h01};
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      // Mode is read after the wait, so a change scheduled with the call is seen.
      dl = forward_pwm ? {m0[38:36], m0[41:39], m0[44:42]} : 9'h000;
      `CHK({chain_devices, scan_lines}, {{1'b0, m0[4:0]} + 6'h01, {1'b0, m0[21:16]} + 7'h01})
      `CHK({subperiods, gray_clock_multiplier}, {{1'b0, m0[24:22], 4'h0} + 8'h10, {1'b0, m0[32:29]} + 5'h01})
      `CHK({predischarge_enable, power_saving_enable, power_saving_plus_level}, {m0[8], m0[12], m0[14:13]})
      `CHK({open_led_removal_enable, short_led_removal_enable, gray_clock_range_select}, {m0[15], m0[47], m0[28]})
      `CHK({red_group_delay, green_group_delay, blue_group_delay}, dl)
      `CHK({red_low_gray_smoothing, green_low_gray_smoothing, blue_low_gray_smoothing}, sm)
      `CHK({red_low_gray_boost, green_low_gray_boost, blue_low_gray_boost}, {m1[28:25], m1[32:29], m1[36:33]})
      `CHK({segment_gray_clocks, line_switch_time, black_field_adjust}, {sg, ls, m1[46:41]})
      `CHK(segment_total_clocks, {1'b0, sg} + {2'b00, ls})
      @(posedge clk_sys);
   endtask
   task automatic tick(input int n, input logic [5:0] li, input logic [6:0] si);
      @(posedge clk_sys);
      seg_tick <= 1'b1;
      repeat (n) @(posedge clk_sys);
      seg_tick <= 1'b0;
      @(negedge clk_sys);
      `CHK({scan_line_index, subperiod_index}, {li, si})
   endtask

   // ======================================================================
   // Clock, watchdog and main sequence.
   // ======================================================================
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   // The sequence needs well under a thousand cycles.
   initial begin
      repeat (5000) @(posedge clk_sys);
      err_count++;
      conclude();
   end
   initial begin
      {rstn, cmd_wr, cmd_rd, cmd_sel, seg_tick} = 5'h00;
      forward_pwm = 1'b1;
      cmd_wdata = 48'h0000_0000_0000;
      err_count = 0;
      compares = 0;
      m0 = RST0;
      m1 = RST1;
      repeat (5) @(posedge clk_sys);
      chk_dec();
      `CHK({cmd_rvalid, scan_line_index, subperiod_index}, 14'h0000)
      rstn <= 1'b1;
      rd(1'b0, RST0);
      rd(1'b1, RST1);
      foreach (ROWS[i]) begin
         wr(ROWS[i].sel, ROWS[i].wd);
         rd(ROWS[i].sel, ROWS[i].rd);
         if (ROWS[i].sel) begin
            m1 = ROWS[i].rd;
         end else begin
            m0 = ROWS[i].rd;
         end
         chk_dec();
      end
      // Sweep every code of the multiplier, subperiod and line switch fields.
      for (int i = 0; i < 16; i++) begin
         m0 = 48'h2000_0000_0000;
         m0[32:29] = i[3:0];
         m0[24:22] = i[2:0];
         m0[21:16] = {i[3:0], i[1:0]};
         m0[4:0] = {i[3:0], 1'b1};
         m1 = 48'h0000_0000_0000;
         m1[40:37] = i[3:0];
         m1[9:0] = 10'h07C + {6'h00, i[3:0]};
         wr(1'b0, m0);
         wr(1'b1, m1);
         chk_dec();
      end
      wr(1'b0, 48'hFFFF_FFFF_FFFF);
      m0 = ROWS[0].rd;
      forward_pwm <= 1'b0;
      chk_dec();
      // Reset in mid-run returns every image to its reset value.
      rstn <= 1'b0;
      m0 = RST0;
      m1 = RST1;
      chk_dec();
      `CHK({cmd_rvalid, scan_line_index, subperiod_index}, 14'h0000)
      rstn <= 1'b1;
      rd(1'b0, RST0);
      rd(1'b1, RST1);
      wr(1'b0, 48'h0000_0001_0000);
      m0 = 48'h2000_0001_0000;
      chk_dec();
      tick(1, 6'h01, 7'h00);
      tick(1, 6'h00, 7'h01);
      tick(29, 6'h01, 7'h0F);
      tick(1, 6'h00, 7'h00);
      conclude();
   end
endmodule // tb_led_matrix_display_config_regs
